// File: bsp_pkg.sv
// constants and types shared by the baseband serial data port
package bsp_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned BIT_PERIOD_0_NS  = 1000;
  localparam int unsigned BIT_PERIOD_1_NS  = 500;
  localparam int unsigned BIT_PERIOD_2_NS  = 250;
  localparam int unsigned BIT_PERIOD_3_NS  = 125;

  // half bit period in clock cycles, rounded down, never below one
  function automatic logic [7:0] half_cycles(input int unsigned period_ns);
    int unsigned n;
    n = period_ns / (2 * CLK_PERIOD_NS);
    half_cycles = (n < 1) ? 8'h01 : 8'(n);
  endfunction

  localparam logic [7:0] HALF_RATE_0 = half_cycles(BIT_PERIOD_0_NS);
  localparam logic [7:0] HALF_RATE_1 = half_cycles(BIT_PERIOD_1_NS);
  localparam logic [7:0] HALF_RATE_2 = half_cycles(BIT_PERIOD_2_NS);
  localparam logic [7:0] HALF_RATE_3 = half_cycles(BIT_PERIOD_3_NS);

  localparam int unsigned PREAMBLE_HEADER_BITS = 192;
  localparam int unsigned CCA_WATCHDOG_NS      = 200000;
  localparam int unsigned CCA_WATCHDOG_CYCLES  = CCA_WATCHDOG_NS / CLK_PERIOD_NS;

  localparam logic [2:0] ADC_FULL_LOW  = 3'h0;
  localparam logic [2:0] ADC_FULL_HIGH = 3'h7;

  localparam logic       BIT_CLOCK_IDLE = 1'b0;

  typedef enum logic [1:0] {
    CCA_ON_LEVEL  = 2'b00,
    CCA_ON_ENERGY = 2'b01,
    CCA_ON_CARRIER = 2'b10,
    CCA_ON_ANY    = 2'b11
  } bsp_cca_mode_type;

  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_HEADER = 2'b01,
    TX_DATA   = 2'b10
  } bsp_tx_state_type;

  typedef enum logic [1:0] {
    RX_OFF  = 2'b00,
    RX_ACQ  = 2'b01,
    RX_DATA = 2'b10
  } bsp_rx_state_type;

endpackage

// File: bsp_bitclk.sv
// bit clock generator: divides the reference clock by a programmable half period
`timescale 1ns/1ns
module bsp_bitclk (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  input  wire logic [7:0] half,
  output logic            clk_q,
  output logic            rise_q,
  output logic            fall_q
);
  logic [7:0] cnt_q;

  // disabled clock parks low so a frame always starts with a full low phase
  always_ff @(posedge clk)
  begin
    if (rst || !en)
    begin
      cnt_q  <= 8'h00;
      clk_q  <= bsp_pkg::BIT_CLOCK_IDLE;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else if (cnt_q >= half - 8'h01)
    begin
      cnt_q  <= 8'h00;
      clk_q  <= !clk_q;
      rise_q <= !clk_q;
      fall_q <= clk_q;
    end
    else
    begin
      cnt_q  <= cnt_q + 8'h01;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
  end
endmodule

// File: bsp_port.sv
// baseband serial data port: transmit, receive, clear channel and adc flag
// Overview of operation
// - transmitter standby unless envelope input active
// - envelope rise starts, fall stops transmit machine
// - sample data on falling edge, phase selectable
// - bit clock rate from signalling rate field
// - ready rises after internal preamble and header
// - ready drops with envelope; internal mode only
// - channel busy from level, energy, carrier; watchdog clears it
// - indicator low when clear, polarity invertible
// - receive clock low during acquisition, runs in data
// - data mode after bit sync and quality ok
// - frame envelope ends on end, length, link loss
// - receiver standby while receive enable low
`timescale 1ns/1ns
module bsp_port #(
  parameter int unsigned HEADER_BITS     = bsp_pkg::PREAMBLE_HEADER_BITS,
  parameter int unsigned WATCHDOG_CYCLES = bsp_pkg::CCA_WATCHDOG_CYCLES
) (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        TX_ENVELOPE_ENABLE,
  input  wire logic        TX_DATA_IN,
  input  wire logic        TX_INT_PREAMBLE,
  input  wire logic        TX_SAMPLE_RISE,
  input  wire logic [1:0]  TX_SIGNAL_RATE,
  output logic             TX_BIT_CLOCK,
  output logic             TX_READY,
  output logic             TX_ACTIVE,
  output logic             TX_BIT_OUT,
  output logic             TX_BIT_VALID,
  input  wire logic [5:0]  SIGNAL_STRENGTH_LEVEL,
  input  wire logic [5:0]  LEVEL_THRESHOLD,
  input  wire logic        ENERGY_DETECT,
  input  wire logic        CARRIER_SENSE,
  input  wire logic [1:0]  CCA_MODE,
  input  wire logic        CCA_INVERT,
  output logic             CHANNEL_CLEAR_INDICATOR,
  input  wire logic        RX_ENVELOPE_ENABLE,
  input  wire logic        BIT_SYNC,
  input  wire logic [7:0]  QUALITY_ESTIMATE,
  input  wire logic [7:0]  QUALITY_THRESHOLD,
  input  wire logic [1:0]  RX_SIGNAL_RATE,
  input  wire logic [15:0] RX_LENGTH,
  input  wire logic        RX_BIT_IN,
  input  wire logic        RX_DATA_END,
  input  wire logic        LINK_LOST,
  output logic             RX_BIT_CLOCK,
  output logic             RX_DATA,
  output logic             RX_BIT_NEXT,
  output logic             RX_FRAME_ENVELOPE,
  output logic             RX_STANDBY,
  input  wire logic [2:0]  I_ADC_CODE,
  input  wire logic [2:0]  Q_ADC_CODE,
  output logic             ADC_CAL_FLAG
);
  if (HEADER_BITS < 1 || HEADER_BITS > 65535 || WATCHDOG_CYCLES < 2)
  begin : g_bad
    $error("bsp_port: unsupported parameter value");
  end

  localparam logic [15:0] HDR_LAST = 16'(HEADER_BITS - 1);
  localparam logic [31:0] WD_LAST  = 32'(WATCHDOG_CYCLES - 1);

  logic [1:0]  tx_env_sync_q;
  logic [1:0]  tx_dat_sync_q;
  logic [1:0]  rx_en_sync_q;
  logic        tx_env_prev_q;
  bsp_pkg::bsp_tx_state_type tx_state_q;
  bsp_pkg::bsp_rx_state_type rx_state_q;
  logic [15:0] hdr_cnt_q;
  logic [15:0] rx_cnt_q;
  logic [1:0]  tx_rate_q;
  logic [7:0]  tx_half;
  logic [7:0]  rx_half;
  logic        tx_rise;
  logic        tx_fall;
  logic        rx_rise;
  logic        rx_fall;
  logic        tx_sample;
  logic        tx_env_rise;
  logic        tx_env_fall;
  logic        busy_raw;
  logic        wd_expired_q;
  logic [31:0] wd_cnt_q;
  logic        rx_stop;
  logic        rx_enter;

  function automatic logic [7:0] rate_half(input logic [1:0] sel);
    unique case (sel)
      2'h0: rate_half = bsp_pkg::HALF_RATE_0;
      2'h1: rate_half = bsp_pkg::HALF_RATE_1;
      2'h2: rate_half = bsp_pkg::HALF_RATE_2;
      2'h3: rate_half = bsp_pkg::HALF_RATE_3;
    endcase
  endfunction

  // envelope, data and receive enable pins pass two flip-flops before use
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      tx_env_sync_q <= 2'h0;
      tx_dat_sync_q <= 2'h0;
      rx_en_sync_q  <= 2'h0;
      tx_env_prev_q <= 1'b0;
    end
    else
    begin
      tx_env_sync_q <= {tx_env_sync_q[0], TX_ENVELOPE_ENABLE};
      tx_dat_sync_q <= {tx_dat_sync_q[0], TX_DATA_IN};
      rx_en_sync_q  <= {rx_en_sync_q[0], RX_ENVELOPE_ENABLE};
      tx_env_prev_q <= tx_env_sync_q[1];
    end
  end

  assign tx_env_rise = tx_env_sync_q[1] && !tx_env_prev_q;
  assign tx_env_fall = !tx_env_sync_q[1] && tx_env_prev_q;

  // transmit side
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      TX_ACTIVE <= 1'b0;
    else
      TX_ACTIVE <= tx_env_sync_q[1];
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      tx_rate_q <= 2'h0;
    else if (tx_env_rise)
      tx_rate_q <= TX_SIGNAL_RATE;
  end

  assign tx_half = rate_half(tx_rate_q);

  bsp_bitclk u_tx_clk (
    .clk    (REF_CLK),
    .rst    (SYS_RST),
    .en     (tx_state_q != bsp_pkg::TX_IDLE),
    .half   (tx_half),
    .clk_q  (TX_BIT_CLOCK),
    .rise_q (tx_rise),
    .fall_q (tx_fall)
  );

  assign tx_sample = TX_SAMPLE_RISE ? tx_rise : tx_fall;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      tx_state_q <= bsp_pkg::TX_IDLE;
      hdr_cnt_q  <= 16'h0000;
      TX_READY   <= 1'b0;
    end
    else if (tx_env_fall || !tx_env_sync_q[1])
    begin
      tx_state_q <= bsp_pkg::TX_IDLE;
      hdr_cnt_q  <= 16'h0000;
      TX_READY   <= 1'b0;
    end
    else
    begin
      unique case (tx_state_q)
        bsp_pkg::TX_IDLE:
          if (tx_env_rise)
            tx_state_q <= TX_INT_PREAMBLE ? bsp_pkg::TX_HEADER : bsp_pkg::TX_DATA;
        bsp_pkg::TX_HEADER:
          if (tx_sample)
          begin
            if (hdr_cnt_q == HDR_LAST)
            begin
              tx_state_q <= bsp_pkg::TX_DATA;
              TX_READY   <= 1'b1;
            end
            hdr_cnt_q <= hdr_cnt_q + 16'h0001;
          end
        bsp_pkg::TX_DATA: ;
        default:
          tx_state_q <= bsp_pkg::TX_IDLE;
      endcase
    end
  end

  // payload bits leave in arrival order, so lsb first is kept
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      TX_BIT_OUT   <= 1'b0;
      TX_BIT_VALID <= 1'b0;
    end
    else
    begin
      TX_BIT_VALID <= tx_sample && tx_state_q == bsp_pkg::TX_DATA && tx_env_sync_q[1];
      if (tx_sample)
        TX_BIT_OUT <= tx_dat_sync_q[1];
    end
  end

  // clear channel assessment
  always_comb
  begin
    unique case (bsp_pkg::bsp_cca_mode_type'(CCA_MODE))
      bsp_pkg::CCA_ON_LEVEL:   busy_raw = SIGNAL_STRENGTH_LEVEL >= LEVEL_THRESHOLD;
      bsp_pkg::CCA_ON_ENERGY:  busy_raw = ENERGY_DETECT;
      bsp_pkg::CCA_ON_CARRIER: busy_raw = CARRIER_SENSE;
      bsp_pkg::CCA_ON_ANY:     busy_raw = ENERGY_DETECT || CARRIER_SENSE ||
                                          SIGNAL_STRENGTH_LEVEL >= LEVEL_THRESHOLD;
    endcase
  end

  // watchdog keeps a stuck busy indication from blocking the channel forever
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST || !busy_raw)
    begin
      wd_cnt_q     <= 32'h0000_0000;
      wd_expired_q <= 1'b0;
    end
    else if (wd_cnt_q == WD_LAST)
      wd_expired_q <= 1'b1;
    else
      wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      CHANNEL_CLEAR_INDICATOR <= 1'b0;
    else
      CHANNEL_CLEAR_INDICATOR <= (busy_raw && !wd_expired_q) ^ CCA_INVERT;
  end

  // receive side
  assign rx_half = rate_half(RX_SIGNAL_RATE);

  bsp_bitclk u_rx_clk (
    .clk    (REF_CLK),
    .rst    (SYS_RST),
    .en     (rx_state_q == bsp_pkg::RX_DATA),
    .half   (rx_half),
    .clk_q  (RX_BIT_CLOCK),
    .rise_q (rx_rise),
    .fall_q (rx_fall)
  );

  assign rx_stop = RX_DATA_END || LINK_LOST ||
                   (rx_rise && rx_cnt_q + 16'h0001 >= RX_LENGTH);

  // entry loads the first bit, so the demodulator must be told to advance then too
  assign rx_enter = rx_state_q == bsp_pkg::RX_ACQ && rx_en_sync_q[1] && BIT_SYNC &&
                    QUALITY_ESTIMATE >= QUALITY_THRESHOLD;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST || !rx_en_sync_q[1])
    begin
      rx_state_q        <= bsp_pkg::RX_OFF;
      rx_cnt_q          <= 16'h0000;
      RX_FRAME_ENVELOPE <= 1'b0;
    end
    else
    begin
      unique case (rx_state_q)
        bsp_pkg::RX_OFF:
          rx_state_q <= bsp_pkg::RX_ACQ;
        bsp_pkg::RX_ACQ:
          if (BIT_SYNC && QUALITY_ESTIMATE >= QUALITY_THRESHOLD)
          begin
            rx_state_q        <= bsp_pkg::RX_DATA;
            rx_cnt_q          <= 16'h0000;
            RX_FRAME_ENVELOPE <= 1'b1;
          end
        bsp_pkg::RX_DATA:
          if (rx_stop)
          begin
            rx_state_q        <= bsp_pkg::RX_ACQ;
            RX_FRAME_ENVELOPE <= 1'b0;
          end
          else if (rx_rise)
            rx_cnt_q <= rx_cnt_q + 16'h0001;
        default:
          rx_state_q <= bsp_pkg::RX_OFF;
      endcase
    end
  end

  // a new bit is put out at each falling bit clock edge, first at frame start
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      RX_DATA     <= 1'b0;
      RX_BIT_NEXT <= 1'b0;
      RX_STANDBY  <= 1'b1;
    end
    else
    begin
      RX_STANDBY  <= !rx_en_sync_q[1];
      RX_BIT_NEXT <= rx_enter || (rx_fall && rx_state_q == bsp_pkg::RX_DATA);
      if (rx_enter || (rx_fall && rx_state_q == bsp_pkg::RX_DATA))
        RX_DATA <= RX_BIT_IN;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      ADC_CAL_FLAG <= 1'b0;
    else
      ADC_CAL_FLAG <= I_ADC_CODE == bsp_pkg::ADC_FULL_LOW ||
                      I_ADC_CODE == bsp_pkg::ADC_FULL_HIGH ||
                      Q_ADC_CODE == bsp_pkg::ADC_FULL_LOW ||
                      Q_ADC_CODE == bsp_pkg::ADC_FULL_HIGH;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  AST_TX_ACTIVE: assert property (TX_ENVELOPE_ENABLE [*4] |-> TX_ACTIVE)
    else $error("transmitter not active under envelope");
  AST_TX_START: assert property (
    tx_env_rise && tx_state_q == bsp_pkg::TX_IDLE |=> tx_state_q != bsp_pkg::TX_IDLE)
    else $error("envelope rise did not start transmit");
  AST_TX_STOP: assert property (tx_env_fall |=> tx_state_q == bsp_pkg::TX_IDLE)
    else $error("envelope fall did not stop transmit");
  AST_TX_SAMPLE: assert property (
    TX_BIT_VALID |-> $past(TX_SAMPLE_RISE) ? $past(tx_rise) : $past(tx_fall))
    else $error("transmit bit taken on wrong clock phase");
  AST_TX_READY_SET: assert property (TX_READY |-> TX_INT_PREAMBLE || $past(TX_READY))
    else $error("ready raised outside internal preamble mode");
  AST_TX_READY_DROP: assert property (!tx_env_sync_q[1] |=> !TX_READY)
    else $error("ready stayed high after envelope dropped");
  AST_CCA_CLEAR: assert property (
    !ENERGY_DETECT && !CARRIER_SENSE && SIGNAL_STRENGTH_LEVEL < LEVEL_THRESHOLD
    |=> CHANNEL_CLEAR_INDICATOR == $past(CCA_INVERT))
    else $error("clear channel shown with wrong polarity");
  AST_RX_CLK_ACQ: assert property (
    rx_state_q != bsp_pkg::RX_DATA && $past(rx_state_q) != bsp_pkg::RX_DATA |-> !RX_BIT_CLOCK)
    else $error("receive clock ran during acquisition");
  AST_RX_ENTER: assert property (
    $past(rx_state_q) == bsp_pkg::RX_ACQ && rx_state_q == bsp_pkg::RX_DATA
    |-> $past(BIT_SYNC) && $past(QUALITY_ESTIMATE) >= $past(QUALITY_THRESHOLD))
    else $error("data mode entered without sync and quality");
  AST_RX_END: assert property (
    rx_state_q == bsp_pkg::RX_DATA && (RX_DATA_END || LINK_LOST) |=> !RX_FRAME_ENVELOPE)
    else $error("frame envelope held after end of data");
  AST_RX_STANDBY: assert property (
    !RX_ENVELOPE_ENABLE [*4] |-> RX_STANDBY && !RX_FRAME_ENVELOPE)
    else $error("receiver not in standby");
  AST_ADC_FLAG: assert property (
    I_ADC_CODE == bsp_pkg::ADC_FULL_LOW || I_ADC_CODE == bsp_pkg::ADC_FULL_HIGH ||
    Q_ADC_CODE == bsp_pkg::ADC_FULL_LOW || Q_ADC_CODE == bsp_pkg::ADC_FULL_HIGH |=> ADC_CAL_FLAG)
    else $error("adc flag missing at full scale");

  COV_TX_READY: cover property ($rose(TX_READY) ##[1:1000] TX_BIT_VALID);
  COV_RX_FRAME: cover property ($rose(RX_FRAME_ENVELOPE) ##[1:1000] $fell(RX_FRAME_ENVELOPE));
  COV_CCA_WD: cover property ($rose(wd_expired_q));
endmodule

// File: bsp_mac_model.sv
// external controller model: sends one word lsb first on the device bit clock
`timescale 1ns/1ns
module bsp_mac_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] word,
  input  wire logic       int_mode,
  input  wire logic       sample_rise,
  input  wire logic       bit_clock,
  input  wire logic       ready,
  output logic            envelope,
  output logic            data,
  output logic            done
);
  logic       clk_q;
  logic       ready_q;
  logic [3:0] idx_q;
  logic       open;
  logic       taken;
  // ready seen a cycle late so the last header edge never counts as payload
  assign open  = envelope & (ready_q | ~int_mode);
  assign taken = sample_rise ? (bit_clock & ~clk_q) : (clk_q & ~bit_clock);
  initial
  begin
    envelope = 1'h0;
    data = 1'h0;
    done = 1'h0;
    idx_q = 4'h0;
    clk_q = 1'h0;
    ready_q = 1'h0;
  end
  always @(posedge clk)
  begin
    clk_q <= bit_clock;
    ready_q <= ready;
    if (!go)
      done <= 1'h0;
    if (go && !envelope && !done)
    begin
      envelope <= 1'h1;
      idx_q <= 4'h0;
    end
    if (open && taken)
      idx_q <= idx_q + 4'h1;
    if (open && idx_q == 4'h8)
    begin
      envelope <= 1'h0;
      done <= 1'h1;
    end
    // idle line toggles so a stale level never passes for data
    data <= open ? word[idx_q[2:0]] : ~data;
  end
endmodule

// File: tb.sv
// self-checking bench for the baseband serial data port
`timescale 1ns/1ns
module tb;
  logic        REF_CLK, SYS_RST, TX_ENVELOPE_ENABLE, TX_DATA_IN, TX_INT_PREAMBLE;
  logic        TX_SAMPLE_RISE, TX_BIT_CLOCK, TX_READY, TX_ACTIVE, TX_BIT_OUT, TX_BIT_VALID;
  logic        ENERGY_DETECT, CARRIER_SENSE, CCA_INVERT, CHANNEL_CLEAR_INDICATOR;
  logic        RX_ENVELOPE_ENABLE, BIT_SYNC, RX_BIT_IN, RX_DATA_END, LINK_LOST, RX_BIT_CLOCK;
  logic        RX_DATA, RX_BIT_NEXT, RX_FRAME_ENVELOPE, RX_STANDBY, ADC_CAL_FLAG;
  logic [1:0]  TX_SIGNAL_RATE, CCA_MODE, RX_SIGNAL_RATE;
  logic [5:0]  SIGNAL_STRENGTH_LEVEL, LEVEL_THRESHOLD;
  logic [7:0]  QUALITY_ESTIMATE, QUALITY_THRESHOLD, tx_word, tx_got, rx_word, rx_got;
  logic [15:0] RX_LENGTH, tx_n, rx_n, hi_cnt, last_hi;
  logic [2:0]  I_ADC_CODE, Q_ADC_CODE, rx_idx;
  logic        go, done, ready_seen, active_seen, hi_done, rck_q;
  int          fails, checked, cyc;

  assign RX_BIT_IN = rx_word[rx_idx];

  bsp_port #(.HEADER_BITS(4), .WATCHDOG_CYCLES(20)) i_dut (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .TX_ENVELOPE_ENABLE(TX_ENVELOPE_ENABLE),
    .TX_DATA_IN(TX_DATA_IN), .TX_INT_PREAMBLE(TX_INT_PREAMBLE),
    .TX_SAMPLE_RISE(TX_SAMPLE_RISE), .TX_SIGNAL_RATE(TX_SIGNAL_RATE),
    .TX_BIT_CLOCK(TX_BIT_CLOCK), .TX_READY(TX_READY), .TX_ACTIVE(TX_ACTIVE),
    .TX_BIT_OUT(TX_BIT_OUT), .TX_BIT_VALID(TX_BIT_VALID),
    .SIGNAL_STRENGTH_LEVEL(SIGNAL_STRENGTH_LEVEL), .LEVEL_THRESHOLD(LEVEL_THRESHOLD),
    .ENERGY_DETECT(ENERGY_DETECT), .CARRIER_SENSE(CARRIER_SENSE), .CCA_MODE(CCA_MODE),
    .CCA_INVERT(CCA_INVERT), .CHANNEL_CLEAR_INDICATOR(CHANNEL_CLEAR_INDICATOR),
    .RX_ENVELOPE_ENABLE(RX_ENVELOPE_ENABLE), .BIT_SYNC(BIT_SYNC),
    .QUALITY_ESTIMATE(QUALITY_ESTIMATE), .QUALITY_THRESHOLD(QUALITY_THRESHOLD),
    .RX_SIGNAL_RATE(RX_SIGNAL_RATE), .RX_LENGTH(RX_LENGTH), .RX_BIT_IN(RX_BIT_IN),
    .RX_DATA_END(RX_DATA_END), .LINK_LOST(LINK_LOST), .RX_BIT_CLOCK(RX_BIT_CLOCK),
    .RX_DATA(RX_DATA), .RX_BIT_NEXT(RX_BIT_NEXT), .RX_FRAME_ENVELOPE(RX_FRAME_ENVELOPE),
    .RX_STANDBY(RX_STANDBY), .I_ADC_CODE(I_ADC_CODE), .Q_ADC_CODE(Q_ADC_CODE),
    .ADC_CAL_FLAG(ADC_CAL_FLAG)
  );

  bsp_mac_model i_mac (
    .clk(REF_CLK), .go(go), .word(tx_word), .int_mode(TX_INT_PREAMBLE),
    .sample_rise(TX_SAMPLE_RISE), .bit_clock(TX_BIT_CLOCK), .ready(TX_READY),
    .envelope(TX_ENVELOPE_ENABLE), .data(TX_DATA_IN), .done(done)
  );

  initial
  begin
    REF_CLK = 1'h0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // monitors; ceiling is several times the expected run length
  always @(posedge REF_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails++;
      test_done();
    end
    rck_q <= RX_BIT_CLOCK;
    if (RX_BIT_CLOCK === 1'h1 && rck_q === 1'h0 && RX_FRAME_ENVELOPE === 1'h1)
    begin
      rx_got <= {RX_DATA, rx_got[7:1]};
      rx_n <= rx_n + 16'h1;
    end
    if (RX_BIT_NEXT === 1'h1)
      rx_idx <= rx_idx + 3'h1;
    if (TX_BIT_VALID === 1'h1)
    begin
      tx_got <= {TX_BIT_OUT, tx_got[7:1]};
      tx_n <= tx_n + 16'h1;
    end
    if (TX_READY === 1'h1)
      ready_seen <= 1'h1;
    if (TX_ACTIVE === 1'h1)
      active_seen <= 1'h1;
    if (TX_BIT_CLOCK === 1'h1)
      hi_cnt <= hi_cnt + 16'h1;
    else if (hi_cnt != 16'h0)
    begin
      hi_cnt <= 16'h0;
      hi_done <= 1'h1;
      if (!hi_done)
        last_hi <= hi_cnt;
    end
  end

  task automatic tx_frame(input logic [1:0] r, input logic im, input logic sr,
                          input logic [7:0] w);
    int n;
    TX_SIGNAL_RATE <= r;
    TX_INT_PREAMBLE <= im;
    TX_SAMPLE_RISE <= sr;
    tx_word <= w;
    tx_n <= 16'h0;
    ready_seen <= 1'h0;
    active_seen <= 1'h0;
    hi_done <= 1'h0;
    @(posedge REF_CLK);
    go <= 1'h1;
    n = 0;
    while (done !== 1'h1 && n < 5000)
    begin
      @(posedge REF_CLK);
      n++;
    end
    go <= 1'h0;
    repeat (6) @(posedge REF_CLK);
    chk(tx_got, w, "tx word");
    chk(tx_n, 16'h8, "tx bits");
    chk(last_hi, (bsp_pkg::BIT_PERIOD_0_NS >> r) / (2 * bsp_pkg::CLK_PERIOD_NS), "half");
    chk(ready_seen, im, "tx ready seen");
    chk(TX_READY, 0, "tx ready after");
    chk(active_seen, 1, "tx active seen");
    chk(TX_ACTIVE, 0, "tx active after");
    chk(TX_BIT_CLOCK, 0, "tx clock parked");
  endtask

  task automatic rx_frame(input logic [7:0] w, input int ab);
    int n;
    rx_word <= w;
    rx_idx <= 3'h0;
    rx_n <= 16'h0;
    QUALITY_ESTIMATE <= 8'h09;
    BIT_SYNC <= 1'h1;
    repeat (20) @(posedge REF_CLK);
    chk(RX_FRAME_ENVELOPE, 0, "rx env acq");
    chk(RX_BIT_CLOCK, 0, "rx clock acq");
    QUALITY_ESTIMATE <= 8'h0A;
    n = 0;
    while (RX_FRAME_ENVELOPE !== 1'h1 && n < 10)
    begin
      @(posedge REF_CLK);
      n++;
    end
    BIT_SYNC <= 1'h0;
    chk(RX_FRAME_ENVELOPE, 1, "rx env entry");
    while (ab != 0 && rx_n < 16'h3 && n < 500)
    begin
      @(posedge REF_CLK);
      n++;
    end
    LINK_LOST <= (ab == 1);
    RX_DATA_END <= (ab == 2);
    repeat (2) @(posedge REF_CLK);
    chk(RX_FRAME_ENVELOPE, ab == 0, "rx env end");
    LINK_LOST <= 1'h0;
    RX_DATA_END <= 1'h0;
    while (RX_FRAME_ENVELOPE === 1'h1 && n < 2000)
    begin
      @(posedge REF_CLK);
      n++;
    end
    chk(rx_n, (ab != 0) ? 16'h3 : 16'h8, "rx bits");
    if (ab == 0)
      chk(rx_got, w, "rx word");
  endtask

  initial
  begin
    {SYS_RST, go, TX_INT_PREAMBLE, TX_SAMPLE_RISE, TX_SIGNAL_RATE} = 6'h20;
    {ENERGY_DETECT, CARRIER_SENSE, CCA_INVERT, CCA_MODE} = 5'h00;
    {RX_ENVELOPE_ENABLE, BIT_SYNC, RX_DATA_END, LINK_LOST} = 4'h0;
    {SIGNAL_STRENGTH_LEVEL, LEVEL_THRESHOLD} = 12'h00A;
    {QUALITY_ESTIMATE, QUALITY_THRESHOLD} = 16'h000A;
    {RX_SIGNAL_RATE, RX_LENGTH, I_ADC_CODE, Q_ADC_CODE} = 24'hC0021B;
    {tx_word, rx_word, rx_idx, rck_q, hi_cnt, hi_done} = 37'h0;
    {fails, checked, cyc} = 96'h0;
    repeat (8) @(posedge REF_CLK);
    SYS_RST <= 1'h0;
    repeat (4) @(posedge REF_CLK);
    chk(RX_STANDBY, 1, "rx standby");
    for (int r = 0; r < 4; r++)
      tx_frame(r[1:0], 1'h0, 1'h0, 8'hA5 ^ r[7:0]);
    tx_frame(2'h3, 1'h0, 1'h1, 8'h3C);
    tx_frame(2'h3, 1'h1, 1'h0, 8'h96);
    tx_frame(2'h2, 1'h1, 1'h1, 8'h81);
    // each source in turn; energy and carrier swap so every mode sees a busy case
    for (int v = 0; v < 8; v++)
    begin
      CCA_MODE <= v[1:0];
      CCA_INVERT <= v[2];
      ENERGY_DETECT <= v[2];
      CARRIER_SENSE <= ~v[2];
      SIGNAL_STRENGTH_LEVEL <= 6'h14;
      repeat (3) @(posedge REF_CLK);
      chk(CHANNEL_CLEAR_INDICATOR, (v[1:0] != {v[2], ~v[2]}) ^ v[2], "cca busy");
      {ENERGY_DETECT, CARRIER_SENSE, SIGNAL_STRENGTH_LEVEL} <= 8'h00;
      repeat (3) @(posedge REF_CLK);
      chk(CHANNEL_CLEAR_INDICATOR, v[2], "cca clear");
    end
    {CCA_MODE, CCA_INVERT, SIGNAL_STRENGTH_LEVEL} <= 9'h014;
    repeat (3) @(posedge REF_CLK);
    chk(CHANNEL_CLEAR_INDICATOR, 1, "cca held");
    repeat (25) @(posedge REF_CLK);
    chk(CHANNEL_CLEAR_INDICATOR, 0, "cca watchdog");
    SIGNAL_STRENGTH_LEVEL <= 6'h00;
    for (int k = 0; k < 16; k++)
    begin
      I_ADC_CODE <= k[3] ? 3'h3 : k[2:0];
      Q_ADC_CODE <= k[3] ? k[2:0] : 3'h4;
      repeat (2) @(posedge REF_CLK);
      chk(ADC_CAL_FLAG, k[2:0] == 3'h0 || k[2:0] == 3'h7, "adc flag");
    end
    RX_ENVELOPE_ENABLE <= 1'h1;
    repeat (5) @(posedge REF_CLK);
    chk(RX_STANDBY, 0, "rx active");
    rx_frame(8'hC9, 0);
    rx_frame(8'h5A, 1);
    rx_frame(8'h33, 2);
    RX_ENVELOPE_ENABLE <= 1'h0;
    repeat (5) @(posedge REF_CLK);
    chk(RX_STANDBY, 1, "rx standby off");
    chk(RX_BIT_CLOCK, 0, "rx clock off");
    test_done();
  end
endmodule
